// *** common/shp_pkg.sv ***
// constants, types and shared decoding for the serial host port
// What this block does
// - parity none, odd or even, both ends
// - seven or eight data bits per frame
// - flow control none, rts/cts or xon/xoff
// - low system reset input resets whole block
// - factory input restores defaults, pin may be disabled
// - trigger pin low at start-up selects command mode
// - after start-up the trigger pin becomes output
// - pin low while connected, high when closed
// - without link, pin toggles once every second
// - link back, pin follows connection state again
package shp_pkg;

	// register port addresses
	localparam logic [2:0] ADDR_CFG  = 3'h0;
	localparam logic [2:0] ADDR_DIV  = 3'h1;
	localparam logic [2:0] ADDR_DATA = 3'h2;
	localparam logic [2:0] ADDR_STAT = 3'h3;
	localparam logic [2:0] ADDR_NET  = 3'h4;

	// clock and timing
	localparam int unsigned CLK_MHZ         = 100;
	localparam int unsigned STARTUP_US      = 10000;
	localparam int unsigned BLINK_MS        = 1000;
	localparam int unsigned STARTUP_CYC_DEF = STARTUP_US * CLK_MHZ;
	localparam int unsigned BLINK_CYC_DEF   = BLINK_MS * 1000 * CLK_MHZ;
	localparam int unsigned STARTUP_W       = 20;
	localparam int unsigned BLINK_W         = 27;

	// flow control characters
	localparam logic [7:0] CHR_XON  = 8'h11;
	localparam logic [7:0] CHR_XOFF = 8'h13;

	// pin synchroniser slots and their reset levels
	localparam int unsigned SYNC_N    = 5;
	localparam int unsigned SYNC_RXD  = 0;
	localparam int unsigned SYNC_CTS  = 1;
	localparam int unsigned SYNC_SYS  = 2;
	localparam int unsigned SYNC_FAC  = 3;
	localparam int unsigned SYNC_TRIG = 4;
	localparam logic [4:0]  SYNC_RST  = 5'h1b;

	typedef enum logic [1:0] {
		PAR_NONE = 2'b00,
		PAR_ODD  = 2'b01,
		PAR_EVEN = 2'b10
	} shp_par_t;

	typedef enum logic [1:0] {
		FLOW_NONE = 2'b00,
		FLOW_HW   = 2'b01,
		FLOW_SW   = 2'b10
	} shp_flow_t;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SEND = 1'b1
	} shp_tx_st_t;

	typedef enum logic [1:0] {
		RX_IDLE  = 2'b00,
		RX_START = 2'b01,
		RX_BITS  = 2'b10,
		RX_STOP  = 2'b11
	} shp_rx_st_t;

	// configuration word, bit 0 upward: parity, eight, flow, fac_pin
	typedef struct packed {
		logic      fac_pin;
		shp_flow_t flow;
		logic      eight;
		shp_par_t  parity;
	} shp_cfg_t;

	// link state written by the network side
	typedef struct packed {
		logic tcp_up;
		logic link_up;
	} shp_net_t;

	// status word, bit 0 upward
	typedef struct packed {
		logic [6:0] zero;
		logic       par_err;
		logic       pin_level;
		logic       started;
		logic       fac_req;
		logic       xoff_held;
		logic       overrun;
		logic       cmd_mode;
		logic       tx_ready;
		logic       rx_avail;
	} shp_stat_t;

	localparam shp_cfg_t    CFG_RST = '{fac_pin: 1'b0, flow: FLOW_NONE, eight: 1'b1,
		parity: PAR_NONE};
	localparam logic [15:0] DIV_RST = 16'h01b2;

	// data plus parity bits in one character
	function automatic logic [3:0] shp_nbits(input shp_cfg_t c);
		return 4'd7 + {3'b000, c.eight} + {3'b000, c.parity != PAR_NONE};
	endfunction

	// parity bit for the selected mode
	function automatic logic shp_par_bit(input logic [7:0] d, input shp_cfg_t c);
		logic x;
		x = ^(c.eight ? d : {1'b0, d[6:0]});
		return (c.parity == PAR_ODD) ? ~x : x;
	endfunction

	// line frame, start bit at bit 0, idle ones above
	function automatic logic [11:0] shp_frame(input logic [7:0] d, input shp_cfg_t c);
		logic [11:0] f;
		f = '1;
		f[0] = 1'b0;
		f[7:1] = d[6:0];
		if (c.eight)
			f[8] = d[7];
		if (c.parity != PAR_NONE)
			f[c.eight ? 9 : 8] = shp_par_bit(d, c);
		return f;
	endfunction

endpackage

// *** logic/shp_buf.sv ***
// two-entry valid/ready buffer on the receive path
`timescale 1ns/1ps
`default_nettype none
module shp_buf
	import shp_pkg::*;
#(
	parameter int W = 8,
	parameter int D = 2
) (
	input  wire logic         ref_clk,
	input  wire logic         nrst,
	input  wire logic         ce,
	input  wire logic         clr,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;

	logic [W-1:0]  mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0]   cnt;
	logic          push;
	logic          pop;

	// full and empty come straight from the fill count
	assign in_ready  = (cnt != (AW+1)'(D));
	assign out_valid = (cnt != '0);
	assign out_data  = mem[rp];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// storage needs no reset, the count guards it
	always_ff @(posedge ref_clk) begin
		if (ce && push)
			mem[wp] <= in_data;
	end

	// pointers and fill count
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			wp  <= '0;
			rp  <= '0;
			cnt <= '0;
		end else if (ce) begin
			if (clr) begin
				wp  <= '0;
				rp  <= '0;
				cnt <= '0;
			end else begin
				if (push)
					wp <= (wp == AW'(D - 1)) ? '0 : wp + 1'b1;
				if (pop)
					rp <= (rp == AW'(D - 1)) ? '0 : rp + 1'b1;
				cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
			end
		end
	end
endmodule
`default_nettype wire

// *** logic/shp_tx.sv ***
// serial character transmitter
`timescale 1ns/1ps
`default_nettype none
module shp_tx
	import shp_pkg::*;
(
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        clr,
	input  wire logic        start,
	input  wire logic [7:0]  data,
	input  wire shp_cfg_t    cfg,
	input  wire logic [15:0] div,
	output logic             busy,
	output logic             txd
);
	shp_tx_st_t  st;
	logic [11:0] sh;
	logic [3:0]  cnt;
	logic [15:0] dcnt;
	logic [3:0]  nbits;

	// start, data, parity and one stop bit
	assign nbits = shp_nbits(cfg) + 4'd2;
	assign busy  = (st == TX_SEND);
	assign txd   = sh[0];

	// shift out one bit every div cycles
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st   <= TX_IDLE;
			sh   <= '1;
			cnt  <= '0;
			dcnt <= '0;
		end else if (ce) begin
			if (clr) begin
				st <= TX_IDLE;
				sh <= '1;
			end else begin
				case (st)
				TX_IDLE: begin
					if (start) begin
						sh   <= shp_frame(data, cfg);
						cnt  <= '0;
						dcnt <= div - 16'h0001;
						st   <= TX_SEND;
					end
				end
				TX_SEND: begin
					if (dcnt == '0) begin
						dcnt <= div - 16'h0001;
						sh   <= {1'b1, sh[11:1]};
						cnt  <= cnt + 4'd1;
						if (cnt == nbits - 4'd1)
							st <= TX_IDLE;
					end else begin
						dcnt <= dcnt - 16'h0001;
					end
				end
				default: st <= TX_IDLE;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** logic/shp_port.sv ***
// serial host port: uart, register port and trigger/status pin
//
// Decided for this implementation: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module shp_port
	import shp_pkg::*;
#(
	parameter int unsigned STARTUP_CYC = STARTUP_CYC_DEF,
	parameter int unsigned BLINK_CYC   = BLINK_CYC_DEF
) (
	input  wire logic        ref_clk,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic [2:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic [15:0]      reg_rdata,
	input  wire logic        rxd,
	output logic             txd,
	input  wire logic        cts_n,
	output logic             rts_n,
	input  wire logic        system_reset_n,
	input  wire logic        factory_default_n,
	input  wire logic        command_trigger_status_i,
	output logic             command_trigger_status_o,
	output logic             command_trigger_status_oe,
	output logic             cmd_mode
);
	// pin synchronisers, two flops each
	logic [SYNC_N-1:0] pin_raw;
	logic [SYNC_N-1:0] pin_s;
	assign pin_raw = {command_trigger_status_i, factory_default_n, system_reset_n,
		cts_n, rxd};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_N; gi++) begin : g_sync
			logic s1;
			logic s2;
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					s1 <= SYNC_RST[gi];
					s2 <= SYNC_RST[gi];
				end else if (ce) begin
					s1 <= pin_raw[gi];
					s2 <= s1;
				end
			end
			assign pin_s[gi] = s2;
		end
	endgenerate

	logic rxd_s;
	logic cts_off;
	logic srst;
	logic fac_s;
	logic trig_s;
	assign rxd_s   = pin_s[SYNC_RXD];
	assign cts_off = pin_s[SYNC_CTS];
	assign fac_s   = pin_s[SYNC_FAC];
	assign trig_s  = pin_s[SYNC_TRIG];
	// pin acts as synchronous whole-block reset
	assign srst    = !pin_s[SYNC_SYS];

	// register state
	shp_cfg_t    cfg;
	logic [15:0] div;
	shp_net_t    net;
	logic        overrun;
	logic        par_err;
	logic        fac_req;
	logic        xoff_held;
	logic        hold_valid;
	logic [7:0]  hold_data;
	logic        startup_done;
	logic        blink_lvl;

	// address decode
	logic sel_cfg;
	logic sel_div;
	logic sel_data;
	logic sel_stat;
	logic sel_net;
	assign sel_cfg  = (reg_addr == ADDR_CFG);
	assign sel_div  = (reg_addr == ADDR_DIV);
	assign sel_data = (reg_addr == ADDR_DATA);
	assign sel_stat = (reg_addr == ADDR_STAT);
	assign sel_net  = (reg_addr == ADDR_NET);

	// factory pin honoured only while enabled
	logic fac_hit;
	assign fac_hit = cfg.fac_pin && !fac_s;

	// transmit path
	logic tx_busy;
	logic tx_go;
	logic hw_stop;
	logic sw_stop;
	// cts off holds the next character
	assign hw_stop = (cfg.flow == FLOW_HW) && cts_off;
	assign sw_stop = (cfg.flow == FLOW_SW) && xoff_held;
	assign tx_go   = hold_valid && !tx_busy && !hw_stop && !sw_stop;

	shp_tx u_tx (
		.ref_clk (ref_clk),
		.nrst    (nrst),
		.ce      (ce),
		.clr     (srst),
		.start   (tx_go),
		.data    (hold_data),
		.cfg     (cfg),
		.div     (div),
		.busy    (tx_busy),
		.txd     (txd)
	);

	// receive state machine
	shp_rx_st_t  rx_st;
	logic [15:0] rx_div;
	logic [3:0]  rx_cnt;
	logic [8:0]  rx_sh;
	logic [3:0]  rx_n;
	logic        rx_fire;
	logic [8:0]  rx_word;
	logic [7:0]  rx_byte;
	logic        rx_pbit;
	logic        rx_bad;
	assign rx_n    = shp_nbits(cfg);
	assign rx_fire = (rx_st == RX_STOP) && (rx_div == '0);
	assign rx_word = rx_sh >> (4'd9 - rx_n);
	// seven-bit characters read back with top bit zero
	assign rx_byte = cfg.eight ? rx_word[7:0] : {1'b0, rx_word[6:0]};
	assign rx_pbit = cfg.eight ? rx_word[8] : rx_word[7];
	// received parity checked against selected mode
	assign rx_bad  = (cfg.parity != PAR_NONE) && (rx_pbit != shp_par_bit(rx_byte, cfg));

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rx_st  <= RX_IDLE;
			rx_div <= '0;
			rx_cnt <= '0;
			rx_sh  <= '0;
		end else if (ce) begin
			if (srst) begin
				rx_st <= RX_IDLE;
			end else begin
				case (rx_st)
				RX_IDLE: begin
					if (!rxd_s) begin
						rx_div <= {1'b0, div[15:1]};
						rx_st  <= RX_START;
					end
				end
				RX_START: begin
					// mid start bit, a glitch drops back to idle
					if (rx_div == '0) begin
						rx_div <= div - 16'h0001;
						rx_cnt <= '0;
						rx_st  <= rxd_s ? RX_IDLE : RX_BITS;
					end else begin
						rx_div <= rx_div - 16'h0001;
					end
				end
				RX_BITS: begin
					if (rx_div == '0) begin
						rx_div <= div - 16'h0001;
						rx_sh  <= {rxd_s, rx_sh[8:1]};
						rx_cnt <= rx_cnt + 4'd1;
						if (rx_cnt == rx_n - 4'd1)
							rx_st <= RX_STOP;
					end else begin
						rx_div <= rx_div - 16'h0001;
					end
				end
				RX_STOP: begin
					if (rx_div == '0)
						rx_st <= RX_IDLE;
					else
						rx_div <= rx_div - 16'h0001;
				end
				default: rx_st <= RX_IDLE;
				endcase
			end
		end
	end

	// received flow characters are consumed, not buffered
	logic is_xon;
	logic is_xoff;
	logic rx_push;
	logic buf_ready;
	logic buf_valid;
	logic [7:0] buf_data;
	logic buf_pop;
	assign is_xon  = (cfg.flow == FLOW_SW) && (rx_byte == CHR_XON);
	assign is_xoff = (cfg.flow == FLOW_SW) && (rx_byte == CHR_XOFF);
	assign rx_push = rx_fire && !is_xon && !is_xoff;
	assign buf_pop = reg_rd && sel_data;

	shp_buf #(
		.W (8),
		.D (2)
	) u_buf (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.ce        (ce),
		.clr       (srst),
		.in_valid  (rx_push),
		.in_ready  (buf_ready),
		.in_data   (rx_byte),
		.out_valid (buf_valid),
		.out_ready (buf_pop),
		.out_data  (buf_data)
	);

	// sticky flags clear on a status read, a new event wins
	logic stat_rd;
	assign stat_rd = reg_rd && sel_stat;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cfg        <= CFG_RST;
			div        <= DIV_RST;
			net        <= '0;
			overrun    <= 1'b0;
			par_err    <= 1'b0;
			fac_req    <= 1'b0;
			xoff_held  <= 1'b0;
			hold_valid <= 1'b0;
			hold_data  <= '0;
			rts_n      <= 1'b0;
		end else if (ce) begin
			if (srst) begin
				cfg        <= CFG_RST;
				div        <= DIV_RST;
				net        <= '0;
				overrun    <= 1'b0;
				par_err    <= 1'b0;
				fac_req    <= 1'b0;
				xoff_held  <= 1'b0;
				hold_valid <= 1'b0;
				rts_n      <= 1'b0;
			end else begin
				if (fac_hit) begin
					cfg <= CFG_RST;
					div <= DIV_RST;
				end else if (reg_wr && sel_cfg) begin
					cfg <= shp_cfg_t'(reg_wdata[5:0]);
				end else if (reg_wr && sel_div) begin
					div <= reg_wdata;
				end
				if (reg_wr && sel_net)
					net <= shp_net_t'(reg_wdata[1:0]);
				// a full holding register ignores further writes
				if (reg_wr && sel_data && !hold_valid) begin
					hold_data  <= reg_wdata[7:0];
					hold_valid <= 1'b1;
				end else if (tx_go) begin
					hold_valid <= 1'b0;
				end
				// xon and xoff steer the held flag
				if (is_xoff && rx_fire)
					xoff_held <= 1'b1;
				else if ((is_xon && rx_fire) || cfg.flow != FLOW_SW)
					xoff_held <= 1'b0;
				overrun <= (rx_push && !buf_ready) || (overrun && !stat_rd);
				par_err <= (rx_fire && rx_bad) || (par_err && !stat_rd);
				fac_req <= fac_hit || (fac_req && !stat_rd);
				// rts drops while the buffer is full
				rts_n <= (cfg.flow == FLOW_HW) && !buf_ready;
			end
		end
	end

	// start-up window, blink timer and trigger/status pin
	logic [STARTUP_W-1:0] su_cnt;
	logic [BLINK_W-1:0]   bl_cnt;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			su_cnt                    <= '0;
			startup_done              <= 1'b0;
			cmd_mode                  <= 1'b0;
			bl_cnt                    <= '0;
			blink_lvl                 <= 1'b1;
			command_trigger_status_o  <= 1'b1;
			command_trigger_status_oe <= 1'b0;
		end else if (ce) begin
			if (srst) begin
				su_cnt                    <= '0;
				startup_done              <= 1'b0;
				cmd_mode                  <= 1'b0;
				bl_cnt                    <= '0;
				blink_lvl                 <= 1'b1;
				command_trigger_status_o  <= 1'b1;
				command_trigger_status_oe <= 1'b0;
			end else begin
				// low pin at window end selects command mode
				if (!startup_done) begin
					su_cnt <= su_cnt + 1'b1;
					if (su_cnt == STARTUP_W'(STARTUP_CYC - 1)) begin
						startup_done <= 1'b1;
						cmd_mode     <= !trig_s;
					end
				end
				// toggle once per second without link
				if (net.link_up) begin
					bl_cnt <= '0;
				end else if (bl_cnt == BLINK_W'(BLINK_CYC - 1)) begin
					bl_cnt    <= '0;
					blink_lvl <= !blink_lvl;
				end else begin
					bl_cnt <= bl_cnt + 1'b1;
				end
				// pin drives connection state after start-up
				command_trigger_status_oe <= startup_done;
				command_trigger_status_o  <= net.link_up ? !net.tcp_up : blink_lvl;
			end
		end
	end

	// status word and read data, valid only the cycle after the strobe
	shp_stat_t stat;
	assign stat = '{zero: 7'h00, par_err: par_err, pin_level: command_trigger_status_o,
		started: startup_done, fac_req: fac_req, xoff_held: xoff_held,
		overrun: overrun, cmd_mode: cmd_mode, tx_ready: !hold_valid,
		rx_avail: buf_valid};

	logic [15:0] rd_mux;
	assign rd_mux = sel_cfg  ? {10'h000, cfg} :
			sel_div  ? div :
			sel_data ? {8'h00, buf_valid ? buf_data : 8'h00} :
			sel_stat ? stat :
			sel_net  ? {14'h0000, net} : 16'h0000;

	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst)
			reg_rdata <= '0;
		else if (ce)
			reg_rdata <= reg_rd ? rd_mux : 16'h0000;
	end

	// checks on the pin, reset and flow behaviour
	cts_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
		(hw_stop && !tx_busy && !srst) |=> !tx_busy)
		else $error("transmit started while cts was off");
	xoff_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
		(sw_stop && !tx_busy && !srst) |=> !tx_busy)
		else $error("transmit started while xoff held");
	pin_input_a: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
		!startup_done |=> !command_trigger_status_oe)
		else $error("trigger pin driven during start-up");
	pin_output_a: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
		(startup_done && !srst) |=> command_trigger_status_oe)
		else $error("status pin not driven after start-up");
	pin_conn_a: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
		(startup_done && net.link_up && net.tcp_up && !srst) |=> !command_trigger_status_o)
		else $error("status pin not low while connected");
	pin_closed_a: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
		(net.link_up && !net.tcp_up && !srst) |=> command_trigger_status_o)
		else $error("status pin not high when closed");
	blink_step_a: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
		(!net.link_up && !srst && bl_cnt == BLINK_W'(BLINK_CYC - 1))
		|=> (blink_lvl != $past(blink_lvl))
		##1 ($past(net.link_up) || command_trigger_status_o == blink_lvl))
		else $error("status pin blink step missed");
	sys_reset_a: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
		srst |=> (!startup_done && !hold_valid && cfg == CFG_RST))
		else $error("system reset did not clear state");
	fac_reset_a: assert property (@(posedge ref_clk) disable iff (!nrst || !ce)
		(fac_hit && !srst) |=> (cfg == CFG_RST && div == DIV_RST && fac_req))
		else $error("factory input did not restore defaults");
endmodule
`default_nettype wire

// *** bench/shp_serial_dev.sv ***
// serial device model on the far side of the host port
`timescale 1ns/1ps
`default_nettype none
module shp_serial_dev (
	input  wire logic ref_clk,
	input  wire logic txd,
	output logic      rxd,
	output logic      cts_n,
	output logic      trig_low
);
	int div = 8;

	// lines idle: rxd high, cts asserted, trigger released
	initial begin
		rxd = 1'b1;
		cts_n = 1'b0;
		trig_low = 1'b0;
	end

	// cts only moved when hardware flow is tested
	task automatic send(input logic [11:0] f, input int nb);
		for (int i = 0; i < nb; i++) begin
			rxd <= f[i];
			repeat (div) @(posedge ref_clk);
		end
		rxd <= 1'b1;
	endtask

	// frame capture from txd
	// mid-bit sampling so a cycle or two of skew is harmless
	task automatic get(input int nb, output logic [11:0] f, output bit ok);
		int n;
		f = '1;
		n = 0;
		while (txd !== 1'b0 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		ok = (n < 400);
		repeat (div / 2) @(posedge ref_clk);
		for (int i = 0; i < nb; i++) begin
			f[i] = txd;
			repeat (div) @(posedge ref_clk);
		end
	endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the serial host port
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import shp_pkg::*;
;
	localparam int BLINK = 16;
	logic        ref_clk = 1'b0;
	logic        nrst = 1'b0;
	logic [2:0]  reg_addr = 3'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        ce = 1'b1;
	logic        system_reset_n = 1'b1;
	logic        factory_default_n = 1'b1;
	logic [15:0] reg_rdata;
	logic        txd, rxd, cts_n, rts_n, pin_o, pin_oe, cmd_mode, trig_low;
	logic [15:0] v;
	logic [7:0]  d;
	logic [7:0]  bd [3];
	int          miscompares = 0;
	int          compares = 0;
	int          t;
	// trigger pin: port drives it when enabled, else pulled up unless the device holds it low
	wire pin = pin_oe ? pin_o : ~trig_low;

	always #5 ref_clk = ~ref_clk;

	shp_port #(.STARTUP_CYC(20), .BLINK_CYC(BLINK)) i_dut (.ref_clk(ref_clk), .nrst(nrst),
		.ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd), .cts_n(cts_n),
		.rts_n(rts_n), .system_reset_n(system_reset_n), .factory_default_n(factory_default_n),
		.command_trigger_status_i(pin), .command_trigger_status_o(pin_o),
		.command_trigger_status_oe(pin_oe), .cmd_mode(cmd_mode));
	shp_serial_dev i_dev (.ref_clk(ref_clk), .txd(txd), .rxd(rxd), .cts_n(cts_n),
		.trig_low(trig_low));

	// expected line frame, worked out independently
	function automatic logic [11:0] xframe(input logic [7:0] c, input int p, input bit e);
		logic [11:0] r;
		r = '1;
		r[0] = 1'b0;
		r[7:1] = c[6:0];
		if (e) r[8] = c[7];
		if (p != 0) r[8 + e] = ^(c & (e ? 8'hff : 8'h7f)) ^ (p == 1);
		return r;
	endfunction

	function automatic int nbits(input int p, input bit e);
		return 9 + e + (p != 0);
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	// register port cycles: one-cycle strobes, read data the cycle after
	task automatic wr(input logic [2:0] a, input logic [15:0] w);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= w;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [15:0] r);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 r = reg_rdata;
	endtask

	task automatic rdchk(input logic [2:0] a, input logic [15:0] e, input string nm);
		logic [15:0] r;
		rd(a, r);
		chk(nm, e, r);
	endtask

	task automatic txchk(input logic [7:0] c, input int p, input bit e);
		logic [11:0] g;
		bit k;
		i_dev.get(nbits(p, e), g, k);
		chk("tx start seen", 16'h0001, {15'h0, k});
		chk("tx frame", {4'h0, xframe(c, p, e)}, {4'h0, g});
	endtask

	// txd must stay idle while flow holds the character
	task automatic quiet(input int n);
		logic q;
		q = 1'b1;
		repeat (n) begin
			@(posedge ref_clk);
			q &= txd;
		end
		chk("txd held idle", 16'h0001, {15'h0, q});
	endtask

	task automatic flip_gap(output int n);
		logic l;
		l = pin;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pin === l && n < 100);
	endtask

	task automatic fac_pulse;
		@(posedge ref_clk);
		factory_default_n <= 1'b0;
		repeat (6) @(posedge ref_clk);
		factory_default_n <= 1'b1;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic tdone(input string nm);
		$display("test %s done", nm);
	endtask

	task automatic close_out;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// watchdog: sequence needs about 2k cycles, 20k allowed
	initial begin
		#200000;
		miscompares++;
		close_out;
	end

	// main sequence
	initial begin
		t = $urandom(46261);
		repeat (5) @(posedge ref_clk);
		chk("txd in reset", 16'h0001, {15'h0, txd});
		chk("pin oe in reset", 16'h0000, {15'h0, pin_oe});
		nrst <= 1'b1;
		repeat (4) @(posedge ref_clk);
		rdchk(ADDR_CFG, 16'h0004, "cfg reset");
		rdchk(ADDR_DIV, 16'h01b2, "div reset");
		rdchk(ADDR_NET, 16'h0000, "net reset");
		wr(3'h5, 16'hffff);
		rdchk(3'h5, 16'h0000, "unmapped");
		repeat (30) @(posedge ref_clk);
		chk("cmd mode high pin", 16'h0000, {15'h0, cmd_mode});
		chk("pin oe after start", 16'h0001, {15'h0, pin_oe});
		tdone("reset");
		// start-up again with the trigger held low
		wr(ADDR_DIV, 16'h0008);
		i_dev.trig_low <= 1'b1;
		system_reset_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		system_reset_n <= 1'b1;
		repeat (6) @(posedge ref_clk);
		chk("pin oe in window", 16'h0000, {15'h0, pin_oe});
		repeat (30) @(posedge ref_clk);
		chk("cmd mode low pin", 16'h0001, {15'h0, cmd_mode});
		i_dev.trig_low <= 1'b0;
		rdchk(ADDR_DIV, 16'h01b2, "div after sys reset");
		tdone("startup");
		// status pin from connection and link
		wr(ADDR_NET, 16'h0003);
		repeat (3) @(posedge ref_clk);
		chk("pin connected", 16'h0000, {15'h0, pin});
		wr(ADDR_NET, 16'h0001);
		repeat (3) @(posedge ref_clk);
		chk("pin closed", 16'h0001, {15'h0, pin});
		wr(ADDR_NET, 16'h0000);
		flip_gap(t);
		for (int i = 0; i < 2; i++) begin
			flip_gap(t);
			chk("blink period", 16'(BLINK), 16'(t));
		end
		wr(ADDR_NET, 16'h0003);
		repeat (40) @(posedge ref_clk);
		chk("pin link back", 16'h0000, {15'h0, pin});
		tdone("status pin");
		// every parity and width, both directions
		wr(ADDR_DIV, 16'h0008);
		for (int p = 0; p < 3; p++) begin
			for (int e = 0; e < 2; e++) begin
				wr(ADDR_CFG, 16'(p + 4 * e));
				d = 8'($urandom);
				wr(ADDR_DATA, {8'h00, d});
				txchk(d, p, e[0]);
				@(posedge ref_clk);
				i_dev.send(xframe(d, p, e[0]), nbits(p, e[0]));
				repeat (4) @(posedge ref_clk);
				rdchk(ADDR_DATA, {8'h00, e[0] ? d : d & 8'h7f}, "rx char");
			end
		end
		// even parity selected: an odd-parity frame is flagged, still stored
		@(posedge ref_clk);
		i_dev.send(xframe(d, 1, 1'b1), 11);
		repeat (4) @(posedge ref_clk);
		rd(ADDR_STAT, v);
		chk("parity error", 16'h0001, {15'h0, v[8]});
		rdchk(ADDR_DATA, {8'h00, d}, "rx bad parity");
		tdone("formats");
		// hardware flow: buffer full drops rts, third char overruns
		wr(ADDR_CFG, 16'h000c);
		for (int i = 0; i < 3; i++) begin
			bd[i] = 8'($urandom);
			@(posedge ref_clk);
			i_dev.send(xframe(bd[i], 0, 1'b1), 10);
		end
		repeat (4) @(posedge ref_clk);
		chk("rts when full", 16'h0001, {15'h0, rts_n});
		rd(ADDR_STAT, v);
		chk("overrun", 16'h0001, {15'h0, v[3]});
		rdchk(ADDR_DATA, {8'h00, bd[0]}, "buf first");
		rdchk(ADDR_DATA, {8'h00, bd[1]}, "buf second");
		rdchk(ADDR_DATA, 16'h0000, "buf empty");
		repeat (3) @(posedge ref_clk);
		chk("rts drained", 16'h0000, {15'h0, rts_n});
		i_dev.cts_n <= 1'b1;
		d = 8'($urandom);
		wr(ADDR_DATA, {8'h00, d});
		quiet(40);
		i_dev.cts_n <= 1'b0;
		txchk(d, 0, 1'b1);
		tdone("hardware flow");
		// software flow: xoff holds, xon releases
		wr(ADDR_CFG, 16'h0014);
		@(posedge ref_clk);
		i_dev.send(xframe(CHR_XOFF, 0, 1'b1), 10);
		repeat (4) @(posedge ref_clk);
		rd(ADDR_STAT, v);
		chk("xoff held", 16'h0001, {15'h0, v[4]});
		chk("xoff not stored", 16'h0000, {15'h0, v[0]});
		d = 8'($urandom);
		wr(ADDR_DATA, {8'h00, d});
		quiet(40);
		@(posedge ref_clk);
		fork
			i_dev.send(xframe(CHR_XON, 0, 1'b1), 10);
			txchk(d, 0, 1'b1);
		join
		tdone("software flow");
		// factory input acts only when enabled
		wr(ADDR_CFG, 16'h0004);
		wr(ADDR_DIV, 16'h0008);
		fac_pulse;
		rdchk(ADDR_DIV, 16'h0008, "factory ignored");
		wr(ADDR_CFG, 16'h0024);
		fac_pulse;
		rdchk(ADDR_DIV, 16'h01b2, "factory restore");
		rd(ADDR_STAT, v);
		chk("factory flag", 16'h0001, {15'h0, v[5]});
		// clock enable low: a write must not land
		ce <= 1'b0;
		wr(ADDR_DIV, 16'h0055);
		ce <= 1'b1;
		rdchk(ADDR_DIV, 16'h01b2, "ce freeze");
		tdone("factory");
		close_out;
	end
endmodule
`default_nettype wire
